/* core/irt_pkg.sv */
// Shared constants and types for the inverting registered transceiver
package irt_pkg;

   // ----------------------------------------------------------------
   // Widths, depths and reset values
   // ----------------------------------------------------------------
   localparam int IRT_WIDTH = 8;
   localparam int IRT_FIFO_DEPTH = 4;
   localparam logic [IRT_WIDTH-1:0] IRT_WORD_RST = 8'h00;
   localparam logic IRT_BIT_RST = 1'b0;

   // Upper limit on element clock toggling, kept by the driving logic
   localparam int IRT_FMAX_MHZ = 175;

   // ----------------------------------------------------------------
   // Logic element selection, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      IRT_ELEM_BUF = 3'h1,
      IRT_ELEM_FF = 3'h2,
      IRT_ELEM_LAT = 3'h4
   } irt_elem_e;

   // ----------------------------------------------------------------
   // Pin inputs as sampled through the synchroniser
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] a_to_b_mode;
      logic [1:0] b_to_a_mode;
      logic a_to_b_clk;
      logic b_to_a_clk;
      logic feedback;
      logic edge_rate;
      logic card_oe;
      logic bp_oe;
      logic bp_oe_n;
      logic [IRT_WIDTH-1:0] card_in;
      logic [IRT_WIDTH-1:0] bp_in;
   } irt_pins_s;

   localparam irt_pins_s IRT_PINS_RST = '0;

endpackage : irt_pkg

/* core/irt_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module irt_fifo
   import irt_pkg::*;
#(
   parameter int WIDTH = IRT_WIDTH,
   parameter int DEPTH = IRT_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } irt_fifo_s;

   irt_fifo_s st_q;
   irt_fifo_s st_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (st_q.count != DEPTH_C);
   assign out_valid = (st_q.count != '0);
   assign out_data = mem_q[st_q.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wr = (st_q.wr == LAST_C) ? '0 : st_q.wr + 1'b1;
      end
      if (pop) begin
         st_d.rd = (st_q.rd == LAST_C) ? '0 : st_q.rd + 1'b1;
      end
      if (push && !pop) begin
         st_d.count = st_q.count + 1'b1;
      end else if (pop && !push) begin
         st_d.count = st_q.count - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Storage has no reset; nothing reads a slot before it is written
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[st_q.wr] <= in_data;
      end
   end

endmodule : irt_fifo

/* core/irt_core.sv */
// Eight-lane inverting registered transceiver with feedback path
// Function
// - The B-to-A element takes backplane data when feedback is low, A-to-B result when high.
// - The looped-back value is the A-to-B element result itself, whatever its mode.
// - Flip-flop mode holds while idle and stores inverted input on a rising clock.
// - Edge-rate select high asks slow backplane edges, low asks fast, backplane only.
// - Latch mode passes inverted data while its enable is high and holds while low.
// - Data is inverted going card to backplane and backplane to card.
// - The card output drives only while its enable is high; elements run regardless.
// - The backplane drives only with true enable high and complement enable low.
`timescale 1ns/100ps
module irt_core
   import irt_pkg::*;
#(
   parameter int WIDTH = IRT_WIDTH,
   parameter int FIFO_DEPTH = IRT_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [IRT_WIDTH-1:0] card_input_lane,
   output logic [IRT_WIDTH-1:0] card_output_lane,
   output logic card_output_lane_oe,
   input wire logic [IRT_WIDTH-1:0] backplane_in,
   output logic [IRT_WIDTH-1:0] backplane_out,
   output logic [IRT_WIDTH-1:0] backplane_oe,
   input wire logic a_to_b_mode_hi,
   input wire logic a_to_b_mode_lo,
   input wire logic b_to_a_mode_hi,
   input wire logic b_to_a_mode_lo,
   input wire logic a_to_b_clock_enable,
   input wire logic b_to_a_clock_enable,
   input wire logic feedback_select,
   input wire logic edge_rate_select,
   input wire logic card_out_enable,
   input wire logic backplane_out_enable,
   input wire logic backplane_out_enable_n,
   output logic backplane_slow_edge,
   output logic a_to_b_ready
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      irt_pins_s s1;
      irt_pins_s s2;
      logic ab_clk_prev;
      logic ba_clk_prev;
      logic [IRT_WIDTH-1:0] ab_elem;
      logic [IRT_WIDTH-1:0] ba_elem;
      logic [IRT_WIDTH-1:0] last_push;
      logic [IRT_WIDTH-1:0] bp_word;
      logic bp_active;
      logic card_active;
      logic slow;
      logic [2:0] warm;
   } irt_core_s;

   irt_core_s st_q;
   irt_core_s st_d;
   irt_pins_s pins;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [IRT_WIDTH-1:0] fifo_out_data;
   logic fifo_out_valid;
   logic [IRT_WIDTH-1:0] ba_source;
   irt_elem_e ab_sel;
   irt_elem_e ba_sel;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic irt_elem_e decode_mode(input logic [1:0] mode);
      irt_elem_e sel;
      sel = IRT_ELEM_BUF;
      if (mode[1]) begin
         sel = IRT_ELEM_LAT;
      end else if (mode[0]) begin
         sel = IRT_ELEM_FF;
      end
      return sel;
   endfunction : decode_mode

   // One shared element for all lanes; controls apply to the whole word
   function automatic logic [IRT_WIDTH-1:0] element(
      input irt_elem_e sel,
      input logic clk_now,
      input logic clk_prev,
      input logic [IRT_WIDTH-1:0] din,
      input logic [IRT_WIDTH-1:0] held
   );
      logic [IRT_WIDTH-1:0] res;
      res = held;
      case (sel)
         IRT_ELEM_BUF: begin
            res = ~din;
         end
         IRT_ELEM_FF: begin
            if (clk_now && !clk_prev) begin
               res = ~din;
            end
         end
         IRT_ELEM_LAT: begin
            if (clk_now) begin
               res = ~din;
            end
         end
         default: begin
            res = held;
         end
      endcase
      return res;
   endfunction : element

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   always_comb begin
      pins = IRT_PINS_RST;
      pins.a_to_b_mode = {a_to_b_mode_hi, a_to_b_mode_lo};
      pins.b_to_a_mode = {b_to_a_mode_hi, b_to_a_mode_lo};
      pins.a_to_b_clk = a_to_b_clock_enable;
      pins.b_to_a_clk = b_to_a_clock_enable;
      pins.feedback = feedback_select;
      pins.edge_rate = edge_rate_select;
      pins.card_oe = card_out_enable;
      pins.bp_oe = backplane_out_enable;
      pins.bp_oe_n = backplane_out_enable_n;
      pins.card_in = card_input_lane;
      pins.bp_in = backplane_in;
   end

   // ----------------------------------------------------------------
   // Element selection
   // ----------------------------------------------------------------
   // Decoded from the synchronised mode pins so a mode change lands
   // together with the data it applies to
   assign ab_sel = decode_mode(st_q.s2.a_to_b_mode);
   assign ba_sel = decode_mode(st_q.s2.b_to_a_mode);

   // Tap is the element result, ahead of any FIFO or driver stage
   assign ba_source = st_q.s2.feedback ? st_q.ab_elem : st_q.s2.bp_in;

   // New A-to-B results queue for the backplane; a change seen while
   // full coalesces into the latest value rather than being lost
   assign fifo_in_valid = (st_q.ab_elem != st_q.last_push);
   assign a_to_b_ready = fifo_in_ready;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.s1 = pins;
      st_d.s2 = st_q.s1;
      st_d.ab_clk_prev = st_q.s2.a_to_b_clk;
      st_d.ba_clk_prev = st_q.s2.b_to_a_clk;
      st_d.warm = {st_q.warm[1:0], 1'b1};
      // Elements update whatever the output enables say, but wait until the
      // synchroniser and clock history hold pin values: a clock pin high
      // through reset would otherwise read as a rising edge
      if (st_q.warm[2]) begin
         st_d.ab_elem = element(ab_sel, st_q.s2.a_to_b_clk, st_q.ab_clk_prev,
                                st_q.s2.card_in, st_q.ab_elem);
         st_d.ba_elem = element(ba_sel, st_q.s2.b_to_a_clk, st_q.ba_clk_prev,
                                ba_source, st_q.ba_elem);
      end
      if (fifo_in_valid && fifo_in_ready) begin
         st_d.last_push = st_q.ab_elem;
      end
      if (fifo_out_valid && st_q.bp_active) begin
         st_d.bp_word = fifo_out_data;
      end
      st_d.bp_active = st_q.s2.bp_oe & ~st_q.s2.bp_oe_n;
      st_d.card_active = st_q.s2.card_oe;
      st_d.slow = st_q.s2.edge_rate;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Backplane queue
   // ----------------------------------------------------------------
   // Inactive backplane stalls the drain, so the queue really fills
   irt_fifo #(
      .WIDTH(IRT_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_ab_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .in_data(st_q.ab_elem),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(st_q.bp_active)
   );

   // ----------------------------------------------------------------
   // Backplane outputs
   // ----------------------------------------------------------------
   // Open-drain backplane: only ever pulls low, high comes from termination
   assign backplane_out = IRT_WORD_RST;
   assign backplane_oe = {IRT_WIDTH{st_q.bp_active}} & ~st_q.bp_word;
   // Edge rate only shapes the backplane drivers, never the card lane
   assign backplane_slow_edge = st_q.slow;

   // ----------------------------------------------------------------
   // Card outputs
   // ----------------------------------------------------------------
   // Lane value keeps following the element while the enable is low
   assign card_output_lane = st_q.ba_elem;
   assign card_output_lane_oe = st_q.card_active;

endmodule : irt_core

/* sim/irt_chk.sv */
// Port-level property checker for the transceiver core
`timescale 1ns/100ps
module irt_chk
   import irt_pkg::*;
#(
   parameter int WIDTH = IRT_WIDTH,
   parameter int FIFO_DEPTH = IRT_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [IRT_WIDTH-1:0] card_input_lane,
   input wire logic [IRT_WIDTH-1:0] card_output_lane,
   input wire logic card_output_lane_oe,
   input wire logic [IRT_WIDTH-1:0] backplane_in,
   input wire logic [IRT_WIDTH-1:0] backplane_out,
   input wire logic [IRT_WIDTH-1:0] backplane_oe,
   input wire logic a_to_b_mode_hi,
   input wire logic a_to_b_mode_lo,
   input wire logic b_to_a_mode_hi,
   input wire logic b_to_a_mode_lo,
   input wire logic a_to_b_clock_enable,
   input wire logic b_to_a_clock_enable,
   input wire logic feedback_select,
   input wire logic edge_rate_select,
   input wire logic card_out_enable,
   input wire logic backplane_out_enable,
   input wire logic backplane_out_enable_n,
   input wire logic backplane_slow_edge,
   input wire logic a_to_b_ready
);
   // ------
   // Settle windows cover the two-flop input synchronisers
   // ------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire act = backplane_out_enable && !backplane_out_enable_n;
   wire ab_buf = !a_to_b_mode_hi && !a_to_b_mode_lo;
   wire ba_buf = !b_to_a_mode_hi && !b_to_a_mode_lo;
   wire ab_ff = !a_to_b_mode_hi && a_to_b_mode_lo;
   property p_oe;
      $stable(card_out_enable)[*4] |-> card_output_lane_oe == card_out_enable;
   endproperty
   a_oe: assert property (p_oe) else $error("card enable not followed");
   property p_slow;
      $stable(edge_rate_select)[*4] |-> backplane_slow_edge == edge_rate_select;
   endproperty
   a_slow: assert property (p_slow) else $error("edge rate not followed");
   property p_bp_off;
      (!act)[*4] |-> backplane_oe == '0;
   endproperty
   a_bp_off: assert property (p_bp_off) else $error("backplane driven while off");
   property p_buf_ba;
      (ba_buf && !feedback_select && $stable(backplane_in))[*6]
         |-> card_output_lane == ~backplane_in;
   endproperty
   a_buf_ba: assert property (p_buf_ba) else $error("card lane not inverse");
   property p_loop;
      (ab_buf && ba_buf && feedback_select && $stable(card_input_lane))[*7]
         |-> card_output_lane == card_input_lane;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback value wrong");
   property p_ff_hold;
      (ab_ff && ba_buf && feedback_select && !a_to_b_clock_enable)[*7]
         |-> $stable(card_output_lane);
   endproperty
   a_ff_hold: assert property (p_ff_hold) else $error("flip-flop not holding");
   property p_latch;
      (a_to_b_mode_hi && a_to_b_clock_enable && ba_buf && feedback_select
         && $stable(card_input_lane))[*7] |-> card_output_lane == card_input_lane;
   endproperty
   a_latch: assert property (p_latch) else $error("latch not passing");
   property p_bp_word;
      (act && ab_buf && a_to_b_ready && $stable(card_input_lane))[*8]
         |-> backplane_oe == card_input_lane;
   endproperty
   a_bp_word: assert property (p_bp_word) else $error("backplane word wrong");
   c_full: cover property (!a_to_b_ready);
   c_ff: cover property (ab_ff && $rose(a_to_b_clock_enable));
   c_act: cover property (act && backplane_oe != '0);
endmodule : irt_chk

bind irt_core irt_chk #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

/* sim/irt_far_side.sv */
// Terminated backplane and card receiver model
`timescale 1ns/100ps
module irt_far_side
   import irt_pkg::*;
(
   input wire logic [IRT_WIDTH-1:0] backplane_out,
   input wire logic [IRT_WIDTH-1:0] backplane_oe,
   input wire logic [IRT_WIDTH-1:0] far_pull,
   input wire logic [IRT_WIDTH-1:0] card_output_lane,
   input wire logic card_output_lane_oe,
   output logic [IRT_WIDTH-1:0] backplane_in,
   output logic [IRT_WIDTH-1:0] card_seen
);
   // ------
   // Termination pulls high; any open-drain puller wins
   // ------
   logic [IRT_WIDTH-1:0] last = '0;
   assign backplane_in = ~((backplane_oe & ~backplane_out) | far_pull);
   always @* if (card_output_lane_oe) last = card_output_lane;
   // Floating card lane shows the inverse so a stale value never matches
   assign card_seen = card_output_lane_oe ? card_output_lane : ~last;
endmodule : irt_far_side

/* sim/tb_top.sv */
// Self-checking bench for the transceiver core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import irt_pkg::*;
   logic mclk, rstn, am_hi, am_lo, bm_hi, bm_lo, aclk, bclk, fb, ers, coe, boe, boe_n;
   logic [IRT_WIDTH-1:0] cin, far, lane, bout, boe_w, bin, seen;
   logic lane_oe, slow, ready;
   int bad_count = 0;
   int total_checks = 0;
   irt_core dut (.mclk(mclk), .rstn(rstn), .card_input_lane(cin), .card_output_lane(lane),
      .card_output_lane_oe(lane_oe), .backplane_in(bin), .backplane_out(bout),
      .backplane_oe(boe_w), .a_to_b_mode_hi(am_hi), .a_to_b_mode_lo(am_lo),
      .b_to_a_mode_hi(bm_hi), .b_to_a_mode_lo(bm_lo), .a_to_b_clock_enable(aclk),
      .b_to_a_clock_enable(bclk), .feedback_select(fb), .edge_rate_select(ers),
      .card_out_enable(coe), .backplane_out_enable(boe), .backplane_out_enable_n(boe_n),
      .backplane_slow_edge(slow), .a_to_b_ready(ready));
   irt_far_side far_side (.backplane_out(bout), .backplane_oe(boe_w), .far_pull(far),
      .card_output_lane(lane), .card_output_lane_oe(lane_oe), .backplane_in(bin),
      .card_seen(seen));
   // ------
   // Tasks
   // ------
   task automatic close_out();
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic set_modes(input logic [1:0] a, input logic [1:0] b, input logic f);
      {am_hi, am_lo} = a;
      {bm_hi, bm_lo} = b;
      fb = f;
      tick(8);
   endtask : set_modes
   initial begin
      mclk = 0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      bad_count++;
      close_out();
   end
   // ------
   // Tests
   // ------
   initial begin
      {am_hi, am_lo, bm_hi, bm_lo, aclk, bclk, fb, ers, coe, boe, boe_n} = '0;
      cin = '0;
      far = '0;
      rstn = 0;
      tick(2);
      rstn = 1;
      tick(1);
      `CHK("reset_oe", 1'b0, lane_oe)
      `CHK("reset_ready", 1'b1, ready)
      coe = 1;
      // Walk one lane at a time
      for (int i = 0; i < IRT_WIDTH; i++) begin
         far = 8'h01 << i;
         tick(8);
         `CHK("ba_buffer", far, seen)
      end
      cin = 8'hA5;
      for (int i = 0; i < 4; i++) begin
         {boe, boe_n} = 2'(i) ^ 2'h1;
         tick(8);
         `CHK("bp_enable", ((i == 3) ? 8'hA5 : 8'h00), boe_w)
      end
      `CHK("bp_wire", 8'h5A, bin)
      `CHK("bp_out_low", 8'h00, bout)
      for (int i = 0; i < 2; i++) begin
         ers = i[0];
         tick(8);
         `CHK("slow_edge", i[0], slow)
      end
      coe = 0;
      far = 8'h3C;
      tick(8);
      `CHK("card_oe_off", 1'b0, lane_oe)
      `CHK("ba_runs_while_off", 8'hBD, lane)
      coe = 1;
      tick(8);
      `CHK("ba_while_off", 8'hBD, seen)
      far = 8'h00;
      set_modes(2'b00, 2'b00, 1'b1);
      `CHK("loop_buf", 8'hA5, lane)
      set_modes(2'b01, 2'b00, 1'b1);
      cin = 8'h0F;
      tick(8);
      `CHK("ff_hold", 8'hA5, lane)
      aclk = 1;
      tick(8);
      `CHK("ff_capture", 8'h0F, lane)
      `CHK("ff_to_bp", 8'h0F, boe_w)
      aclk = 0;
      tick(8);
      for (int m = 2; m < 4; m++) begin
         set_modes(2'(m), 2'b00, 1'b1);
         aclk = 1;
         cin = 8'h33 ^ 8'(m);
         tick(8);
         `CHK("latch_pass", 8'h33 ^ 8'(m), lane)
         aclk = 0;
         tick(8);
         cin = 8'hFF;
         tick(8);
         `CHK("latch_hold", 8'h33 ^ 8'(m), lane)
      end
      boe = 0;
      set_modes(2'b00, 2'b00, 1'b0);
      set_modes(2'b00, 2'b01, 1'b0);
      far = 8'h81;
      tick(8);
      `CHK("ba_ff_hold", 8'h00, lane)
      bclk = 1;
      tick(8);
      `CHK("ba_ff_capture", 8'h81, lane)
      set_modes(2'b00, 2'b10, 1'b0);
      far = 8'h42;
      tick(8);
      `CHK("ba_latch", 8'h42, lane)
      // Backplane stalled: results pile up until refused
      for (int k = 1; k < 7; k++) begin
         cin = 8'(k);
         tick(4);
      end
      `CHK("fifo_full", 1'b0, ready)
      boe = 1;
      tick(16);
      `CHK("fifo_drained", 1'b1, ready)
      `CHK("bp_last", 8'h06, boe_w)
      // Clock held high across a reset must not count as a rising edge
      set_modes(2'b01, 2'b00, 1'b1);
      aclk = 1;
      cin = 8'h00;
      tick(8);
      rstn = 0;
      tick(1);
      `CHK("rst_lane", IRT_WORD_RST, lane)
      `CHK("rst_lane_oe", 1'b0, lane_oe)
      `CHK("rst_bp_oe", IRT_WORD_RST, boe_w)
      `CHK("rst_slow", 1'b0, slow)
      `CHK("rst_ready", 1'b1, ready)
      rstn = 1;
      tick(8);
      `CHK("ff_no_false_edge", ~IRT_WORD_RST, lane)
      close_out();
   end
endmodule : tb_top
